// >>> hw/ncd_core.sv
// nibble cpu datapath: registers, flags, alu, paged pc, stack, ram, peripheral select
`timescale 1ns/1ns
// Function
// - accumulator is a 4-bit operand/result register with rotates and transfers.
// - ram holds 128 nibbles addressed by row low three bits and column.
// - lookup pointer is a general nibble or middle of the table lookup address.
// - peripheral select pointer is a general nibble or the peripheral number.
// - bank flag 0 routes to ram pointers, 1 to lookup and peripheral pointers.
// - set-bank sets the bank flag, clear-bank clears it, reset clears it.
// - carry is carry-out after add and not-borrow after subtract.
// - set-carry and clear-carry force carry; rotates pass through carry.
// - carry and branch flag hold until the next instruction executes.
// - branch flag follows carry on arithmetic, zero logic or compare gives 0, bit test gives the bit, interrupt return restores it, else 1.
// - conditional branch is taken when branch flag is 1.
// - alu does add, subtract, compare, and, or, xor, rotate with flags.
// - program memory is 32 pages of 64 bytes addressed by the counter.
// - counter low six bits pick the byte, upper five the page; reset zero.
// - short jump replaces only the six in-page bits.
// - long jump and call load a full 11-bit address.
// - stack keeps eight addresses plus interrupt context; returns restore them.
// - stack index is 3 bits, up on call or interrupt, down on return.
// - stack index wraps and later pushes overwrite without any error.
// - bit operations set, clear or test one bit of a ram nibble.
// - 32 peripheral registers in two tables; reads return pins, writes drive them.
// - bit 0 of the table select register picks table 0 or 1; reset table 0.
// - table select register sits at number 0 in both tables.
module ncd_core
   import ncd_pkg::*;
(
   input  wire logic                  sys_clk,       // clock, 10 MHz
   input  wire logic                  rst,           // async reset, active high
   input  wire logic                  op_valid,      // one instruction executes
   input  wire ncd_instr_t            instr,         // decoded instruction
   input  wire logic [NIB_W-1:0]      periph_rdata,  // peripheral read data
   input  wire logic [ROM_DATA_W-1:0] rom_data,      // table lookup byte
   input  wire logic [ROM_HI_W-1:0]   rom_hi,        // upper lookup address bits
   output logic      [PC_W-1:0]       pc_out,        // fetch address
   output logic      [PC_W-1:0]       lookup_addr,   // table lookup address
   output logic      [PH_NUM_W-1:0]   periph_num,    // table bit and number
   output logic                       periph_rd,     // peripheral read strobe
   output logic                       periph_wr,     // peripheral write pulse
   output logic      [PH_NUM_W-1:0]   periph_wnum,   // number of the write
   output logic      [NIB_W-1:0]      periph_wdata,  // peripheral write data
   output logic      [NIB_W-1:0]      accum_out,     // accumulator
   output logic                       carry_out,     // carry flag
   output logic                       branch_out,    // branch condition flag
   output logic                       bank_out,      // register bank flag
   output logic      [SP_W-1:0]       sp_out         // stack index
);

   logic [NIB_W-1:0]    accum_q, row_q, col_q, lookup_q, psel_q;
   logic                bank_q, carry_q, cond_q, tbl_q;
   logic [PC_W-1:0]     pc_q;
   logic                ph_wr_q;
   logic [PH_NUM_W-1:0] ph_wnum_q;
   logic [NIB_W-1:0]    ph_wdata_q;
   logic [NIB_W-1:0]    ram_q [RAM_DEPTH];

   logic [NIB_W-1:0]    accum_d, row_d, col_d, lookup_d, psel_d;
   logic                carry_d, cond_d, bank_d, tbl_d;
   logic [PC_W-1:0]     pc_d;
   logic                ram_we;
   logic [NIB_W-1:0]    ram_wdata;

   // one-hot bit mask for the bit operations
   function automatic logic [NIB_W-1:0] bit_mask(input logic [1:0] sel);
      bit_mask = NIB_W'(4'h1 << sel);
   endfunction

   wire ncd_op_t code = instr.code;
   wire          exec = op_valid;

   wire [RAM_AW-1:0] ram_addr = {row_q[ROW_USED_W-1:0], col_q};
   wire [NIB_W-1:0]  ram_rd   = ram_q[ram_addr];
   wire [NIB_W-1:0]  mask     = bit_mask(instr.bit_sel);

   wire [PC_W-1:0] pc_inc  = pc_q + PC_ONE;
   wire [PC_W-1:0] pc_page = {pc_q[PC_W-1:PAGE_LO_W], instr.addr[PAGE_LO_W-1:0]};

   // number zero is the table select in both tables
   wire is_tbl_sel = (psel_q == TBL_SEL_NUM);

   wire is_arith = (code == add_op) || (code == sub_op);
   wire is_logic = (code == and_op) || (code == or_op) ||
                   (code == xor_op) || (code == not_equal_logic_op);
   wire is_rot   = (code == rotate_left_op) || (code == rotate_right_op);

   ncd_alu_fn_t alu_fn;
   assign alu_fn = (code == add_op)             ? ALU_ADD :
                   (code == sub_op)             ? ALU_SUB :
                   (code == compare_op)         ? ALU_SUB :
                   (code == and_op)             ? ALU_AND :
                   (code == or_op)              ? ALU_OR  :
                   (code == xor_op)             ? ALU_XOR :
                   (code == not_equal_logic_op) ? ALU_XOR :
                   (code == rotate_left_op)     ? ALU_ROL :
                   (code == rotate_right_op)    ? ALU_ROR : ALU_PASS;

   logic [NIB_W-1:0] alu_res;
   logic             alu_cout, alu_zero;

   ncd_alu u_alu (
      .a      (accum_q),
      .b      (ram_rd),
      .cin    (carry_q),
      .fn     (alu_fn),
      .result (alu_res),
      .cout   (alu_cout),
      .zero   (alu_zero)
   );

   wire stk_push = exec && ((code == call_op) || (code == interrupt_entry_op));
   wire stk_pop  = exec && ((code == return_op) || (code == interrupt_return_op));
   wire stk_ctx  = (code == interrupt_entry_op);

   ncd_ctx_t        ctx_now, ctx_saved;
   logic [PC_W-1:0] stk_top;
   logic [SP_W-1:0] sp;

   assign ctx_now = '{accum: accum_q, row: row_q, col: col_q, lookup: lookup_q,
                      psel: psel_q, carry: carry_q, cond: cond_q};

   ncd_stack u_stack (
      .sys_clk  (sys_clk),
      .rst      (rst),
      .push     (stk_push),
      .pop      (stk_pop),
      .save_ctx (stk_ctx),
      .pc_in    (code == call_op ? pc_inc : pc_q),
      .ctx_in   (ctx_now),
      .pc_top   (stk_top),
      .ctx_out  (ctx_saved),
      .sp       (sp)
   );

   always_comb begin
      accum_d   = accum_q;
      row_d     = row_q;
      col_d     = col_q;
      lookup_d  = lookup_q;
      psel_d    = psel_q;
      carry_d   = carry_q;
      // other instructions leave the branch flag at 1
      cond_d    = 1'b1;
      bank_d    = bank_q;
      tbl_d     = tbl_q;
      pc_d      = pc_inc;
      ram_we    = 1'b0;
      ram_wdata = ram_rd;
      unique case (code)
         no_op: ;
         load_imm_op: accum_d = instr.imm;
         add_op, sub_op: begin
            accum_d = alu_res;
            carry_d = alu_cout;
            cond_d  = alu_cout;
         end
         // zero result clears the branch flag
         compare_op: cond_d = !alu_zero;
         and_op, or_op, xor_op: begin
            accum_d = alu_res;
            cond_d  = !alu_zero;
         end
         not_equal_logic_op: cond_d = !alu_zero;
         rotate_left_op, rotate_right_op: begin
            accum_d = alu_res;
            carry_d = alu_cout;
         end
         set_carry_op:   carry_d = 1'b1;
         clear_carry_op: carry_d = 1'b0;
         set_bank_flag_op:   bank_d = 1'b1;
         clear_bank_flag_op: bank_d = 1'b0;
         ram_load_op: accum_d = ram_rd;
         ram_store_op: begin
            ram_we    = 1'b1;
            ram_wdata = accum_q;
         end
         bit_set_op: begin
            ram_we    = 1'b1;
            ram_wdata = ram_rd | mask;
         end
         bit_clear_op: begin
            ram_we    = 1'b1;
            ram_wdata = ram_rd & ~mask;
         end
         bit_test_op: cond_d = |(ram_rd & mask);
         move_to_row_op: begin
            if (bank_q) lookup_d = accum_q;
            else row_d = accum_q;
         end
         move_to_col_op: begin
            if (bank_q) psel_d = accum_q;
            else col_d = accum_q;
         end
         // pins seen through the selected register
         periph_read_op: accum_d = is_tbl_sel ? {3'h0, tbl_q} : periph_rdata;
         // table select written from bit 0
         periph_write_op: begin
            if (is_tbl_sel) tbl_d = accum_q[TBL_SEL_BIT];
         end
         // lookup byte low nibble lands in ram
         rom_to_ram_transfer_op: begin
            ram_we    = 1'b1;
            ram_wdata = rom_data[NIB_W-1:0];
         end
         // taken on flag 1, target inside the page
         cond_branch_op: begin
            if (cond_q) pc_d = pc_page;
         end
         page_jump_op: pc_d = pc_page;
         long_jump_op, call_op: pc_d = instr.addr;
         return_op: pc_d = stk_top;
         interrupt_return_op: begin
            pc_d     = stk_top;
            accum_d  = ctx_saved.accum;
            row_d    = ctx_saved.row;
            col_d    = ctx_saved.col;
            lookup_d = ctx_saved.lookup;
            psel_d   = ctx_saved.psel;
            carry_d  = ctx_saved.carry;
            cond_d   = ctx_saved.cond;
         end
         // interrupted instruction is replayed after return
         interrupt_entry_op: pc_d = instr.addr;
      endcase
   end

   // data registers take zero at reset only for a known start
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         accum_q  <= NIB_ZERO;
         row_q    <= NIB_ZERO;
         col_q    <= NIB_ZERO;
         lookup_q <= NIB_ZERO;
         psel_q   <= NIB_ZERO;
         carry_q  <= 1'b0;
         cond_q   <= 1'b0;
      // flags move only when an instruction executes
      end else if (exec) begin
         accum_q  <= accum_d;
         row_q    <= row_d;
         col_q    <= col_d;
         lookup_q <= lookup_d;
         psel_q   <= psel_d;
         carry_q  <= carry_d;
         cond_q   <= cond_d;
      end
   end

   // counter, bank and table reset values
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         pc_q   <= PC_RESET;
         bank_q <= BANK_RESET;
         tbl_q  <= TBL_RESET;
      end else if (exec) begin
         pc_q   <= pc_d;
         bank_q <= bank_d;
         tbl_q  <= tbl_d;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         ph_wr_q    <= 1'b0;
         ph_wnum_q  <= '0;
         ph_wdata_q <= NIB_ZERO;
      end else begin
         ph_wr_q <= exec && (code == periph_write_op) && !is_tbl_sel;
         if (exec && (code == periph_write_op)) begin
            ph_wnum_q  <= {tbl_q, psel_q};
            ph_wdata_q <= accum_q;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (exec && ram_we) begin
         ram_q[ram_addr] <= ram_wdata;
      end
   end

   // peripheral number from the select pointer
   assign periph_num   = {tbl_q, psel_q};
   assign periph_rd    = exec && (code == periph_read_op) && !is_tbl_sel;
   assign periph_wr    = ph_wr_q;
   assign periph_wnum  = ph_wnum_q;
   assign periph_wdata = ph_wdata_q;
   assign lookup_addr  = {rom_hi, lookup_q, accum_q};
   assign pc_out       = pc_q;
   assign accum_out    = accum_q;
   assign carry_out    = carry_q;
   assign branch_out   = cond_q;
   assign bank_out     = bank_q;
   assign sp_out       = sp;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   a_bank_set_flag: assert property (
      exec && code == set_bank_flag_op |=> bank_q ##1 (bank_q || $past(exec)))
      else $error("bank flag not set");
   a_bank_clear_flag: assert property (
      exec && code == clear_bank_flag_op |=> !bank_q)
      else $error("bank flag not cleared");
   a_pc_seq_step: assert property (
      exec && code == no_op |=> pc_q == PC_W'($past(pc_q) + PC_ONE))
      else $error("counter did not step");
   a_short_jump_page: assert property (
      exec && code == page_jump_op |=> pc_q[PC_W-1:PAGE_LO_W] ==
      $past(pc_q[PC_W-1:PAGE_LO_W]) && pc_q[PAGE_LO_W-1:0] == $past(instr.addr[PAGE_LO_W-1:0]))
      else $error("short jump left the page");
   a_long_jump_full: assert property (
      exec && (code == long_jump_op || code == call_op) |=> pc_q == $past(instr.addr))
      else $error("long jump target wrong");
   a_add_carry_out: assert property (
      exec && code == add_op |=> carry_q == $past(alu_cout) && cond_q == carry_q)
      else $error("add carry wrong");
   a_logic_zero_flag: assert property (
      exec && is_logic && alu_zero |=> !cond_q)
      else $error("zero logic result left flag set");
   a_flags_hold_idle: assert property (
      !exec |=> $stable(carry_q) && $stable(cond_q))
      else $error("flag changed without instruction");
   a_branch_not_taken: assert property (
      exec && code == cond_branch_op && !cond_q |=> pc_q == PC_W'($past(pc_q) + PC_ONE))
      else $error("branch taken on flag 0");
   a_call_sp_up: assert property (
      exec && code == call_op |=> sp == SP_W'($past(sp) + SP_ONE))
      else $error("stack index not incremented");
   a_call_ret_pair: assert property (
      exec && code == call_op ##1 (exec && code == return_op)
      |=> pc_q == PC_W'($past(pc_q, 2) + PC_ONE))
      else $error("return address wrong");
   a_table_sel_write: assert property (
      exec && code == periph_write_op && is_tbl_sel |=> tbl_q == $past(accum_q[0]))
      else $error("table select not written");
   a_rotate_carry: assert property (
      exec && code == rotate_left_op |=> carry_q == $past(accum_q[NIB_W-1]))
      else $error("rotate carry wrong");

   c_call_return: cover property (exec && code == call_op ##[1:20] exec && code == return_op);
   c_table_switch: cover property (exec && code == periph_write_op && is_tbl_sel);
   c_branch_taken: cover property (exec && code == cond_branch_op && cond_q);
   c_interrupt_ret: cover property (
      exec && code == interrupt_entry_op ##[1:20] exec && code == interrupt_return_op);

endmodule // ncd_core

// >>> include/ncd_pkg.sv
// shared constants and types for the nibble cpu datapath
package ncd_pkg;

   localparam int NIB_W      = 4;
   localparam int PC_W       = 11;
   localparam int PAGE_LO_W  = 6;
   localparam int SP_W       = 3;
   localparam int STK_DEPTH  = 8;
   localparam int RAM_AW     = 7;
   localparam int RAM_DEPTH  = 128;
   localparam int ROW_USED_W = 3;
   localparam int PH_NUM_W   = 5;
   localparam int ROM_HI_W   = 3;
   localparam int ROM_DATA_W = 8;

   localparam logic [PC_W-1:0]  PC_RESET      = 11'h000;
   localparam logic [PC_W-1:0]  PC_ONE        = 11'h001;
   localparam logic [SP_W-1:0]  SP_RESET      = 3'h0;
   localparam logic [SP_W-1:0]  SP_ONE        = 3'h1;
   localparam logic             BANK_RESET    = 1'b0;
   localparam logic             TBL_RESET     = 1'b0;
   localparam logic [NIB_W-1:0] NIB_ZERO      = 4'h0;
   localparam logic [NIB_W-1:0] TBL_SEL_NUM   = 4'h0;
   localparam int               TBL_SEL_BIT   = 0;

   typedef enum logic [4:0] {
      no_op                  = 5'b00000,
      load_imm_op            = 5'b00001,
      add_op                 = 5'b00010,
      sub_op                 = 5'b00011,
      compare_op             = 5'b00100,
      and_op                 = 5'b00101,
      or_op                  = 5'b00110,
      xor_op                 = 5'b00111,
      not_equal_logic_op     = 5'b01000,
      rotate_left_op         = 5'b01001,
      rotate_right_op        = 5'b01010,
      set_carry_op           = 5'b01011,
      clear_carry_op         = 5'b01100,
      set_bank_flag_op       = 5'b01101,
      clear_bank_flag_op     = 5'b01110,
      ram_load_op            = 5'b01111,
      ram_store_op           = 5'b10000,
      bit_set_op             = 5'b10001,
      bit_clear_op           = 5'b10010,
      bit_test_op            = 5'b10011,
      move_to_row_op         = 5'b10100,
      move_to_col_op         = 5'b10101,
      periph_read_op         = 5'b10110,
      periph_write_op        = 5'b10111,
      rom_to_ram_transfer_op = 5'b11000,
      cond_branch_op         = 5'b11001,
      page_jump_op           = 5'b11010,
      long_jump_op           = 5'b11011,
      call_op                = 5'b11100,
      return_op              = 5'b11101,
      interrupt_return_op    = 5'b11110,
      interrupt_entry_op     = 5'b11111
   } ncd_op_t;

   typedef enum logic [2:0] {
      ALU_ADD  = 3'b000,
      ALU_SUB  = 3'b001,
      ALU_AND  = 3'b010,
      ALU_OR   = 3'b011,
      ALU_XOR  = 3'b100,
      ALU_ROL  = 3'b101,
      ALU_ROR  = 3'b110,
      ALU_PASS = 3'b111
   } ncd_alu_fn_t;

   typedef struct packed {
      ncd_op_t          code;
      logic [NIB_W-1:0] imm;
      logic [1:0]       bit_sel;
      logic [PC_W-1:0]  addr;
   } ncd_instr_t;

   // context kept for an interrupt: five nibbles and two flags
   typedef struct packed {
      logic [NIB_W-1:0] accum;
      logic [NIB_W-1:0] row;
      logic [NIB_W-1:0] col;
      logic [NIB_W-1:0] lookup;
      logic [NIB_W-1:0] psel;
      logic             carry;
      logic             cond;
   } ncd_ctx_t;

endpackage

// >>> hw/ncd_alu.sv
// 4-bit alu with carry, borrow and zero detection
`timescale 1ns/1ns
module ncd_alu
   import ncd_pkg::*;
(
   input  wire logic [NIB_W-1:0] a,      // accumulator operand
   input  wire logic [NIB_W-1:0] b,      // second operand
   input  wire logic             cin,    // carry in
   input  wire ncd_alu_fn_t      fn,     // operation
   output logic      [NIB_W-1:0] result, // result nibble
   output logic                  cout,   // carry, or not-borrow on subtract
   output logic                  zero    // result is zero
);

   wire [NIB_W:0] sum_w  = {1'b0, a} + {1'b0, b};
   // a + ~b + 1: top bit is 1 when no borrow
   wire [NIB_W:0] diff_w = {1'b0, a} + {1'b0, ~b} + 5'h01;

   always_comb begin
      result = a;
      cout   = cin;
      unique case (fn)
         ALU_ADD: begin
            result = sum_w[NIB_W-1:0];
            cout   = sum_w[NIB_W];
         end
         ALU_SUB: begin
            result = diff_w[NIB_W-1:0];
            cout   = diff_w[NIB_W];
         end
         ALU_AND:  result = a & b;
         ALU_OR:   result = a | b;
         ALU_XOR:  result = a ^ b;
         ALU_ROL: begin
            result = {a[NIB_W-2:0], cin};
            cout   = a[NIB_W-1];
         end
         ALU_ROR: begin
            result = {cin, a[NIB_W-1:1]};
            cout   = a[0];
         end
         ALU_PASS: result = a;
      endcase
   end

   assign zero = (result == NIB_ZERO);

endmodule // ncd_alu

// >>> hw/ncd_stack.sv
// eight-entry return address stack with interrupt context slot
`timescale 1ns/1ns
module ncd_stack
   import ncd_pkg::*;
(
   input  wire logic            sys_clk,  // clock
   input  wire logic            rst,      // async reset, active high
   input  wire logic            push,     // call or interrupt entry
   input  wire logic            pop,      // return or interrupt return
   input  wire logic            save_ctx, // interrupt entry saves context
   input  wire logic [PC_W-1:0] pc_in,    // address pushed
   input  wire ncd_ctx_t        ctx_in,   // context saved
   output logic      [PC_W-1:0] pc_top,   // address of last push
   output ncd_ctx_t             ctx_out,  // saved context
   output logic      [SP_W-1:0] sp        // stack index
);

   logic [PC_W-1:0] pc_mem_q [STK_DEPTH];
   ncd_ctx_t        ctx_q;
   logic [SP_W-1:0] sp_q;

   wire [SP_W-1:0] top_idx = sp_q - SP_ONE;

   // wraps silently, so deep nesting overwrites older entries
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         sp_q <= SP_RESET;
      end else if (push) begin
         sp_q <= sp_q + SP_ONE;
      end else if (pop) begin
         sp_q <= top_idx;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (push) begin
         pc_mem_q[sp_q] <= pc_in;
      end
      if (push && save_ctx) begin
         ctx_q <= ctx_in;
      end
   end

   assign pc_top  = pc_mem_q[top_idx];
   assign ctx_out = ctx_q;
   assign sp      = sp_q;

endmodule // ncd_stack

// >>> sim/ncd_core_tb.sv
// self-checking bench for the nibble cpu datapath
`timescale 1ns/1ns
module ncd_core_tb;
   import ncd_pkg::*;
   logic                  sys_clk      = 1'b0;
   logic                  rst          = 1'b1;
   logic                  op_valid     = 1'b0;
   ncd_instr_t            instr        = '0;
   logic [NIB_W-1:0]      periph_rdata = 4'h6;
   logic [ROM_DATA_W-1:0] rom_data     = 8'hD3;
   logic [ROM_HI_W-1:0]   rom_hi       = 3'h0;
   logic [PC_W-1:0]       pc_out, lookup_addr;
   logic [PH_NUM_W-1:0]   periph_num, periph_wnum;
   logic [NIB_W-1:0]      periph_wdata, accum_out;
   logic                  periph_rd, periph_wr, carry_out, branch_out, bank_out;
   logic [SP_W-1:0]       sp_out;
   int                    err_count = 0;
   int                    cmp_count = 0;
   int                    cyc       = 0;

   ncd_core dut (.sys_clk(sys_clk), .rst(rst), .op_valid(op_valid), .instr(instr),
      .periph_rdata(periph_rdata), .rom_data(rom_data), .rom_hi(rom_hi), .pc_out(pc_out),
      .lookup_addr(lookup_addr), .periph_num(periph_num), .periph_rd(periph_rd),
      .periph_wr(periph_wr), .periph_wnum(periph_wnum), .periph_wdata(periph_wdata),
      .accum_out(accum_out), .carry_out(carry_out), .branch_out(branch_out),
      .bank_out(bank_out), .sp_out(sp_out));

   always #50 sys_clk = ~sys_clk;

   // ceiling well above the roughly 125 cycles the tests need
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         err_count = err_count + 1;
         stop_test();
      end
   end

   task automatic chk(input string name, input logic [PC_W-1:0] seen, input logic [PC_W-1:0] exp);
      cmp_count = cmp_count + 1;
      if (seen !== exp) begin
         err_count = err_count + 1;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // drives at the edge; the following edge takes it, outputs of the prior op settle by #1
   task automatic op(input logic v, input ncd_op_t c, input logic [3:0] i = 4'h0,
                     input logic [PC_W-1:0] a = 11'h000, input logic [1:0] b = 2'h0);
      @(posedge sys_clk);
      op_valid <= v;
      instr    <= '{code: c, imm: i, bit_sel: b, addr: a};
      #1;
   endtask

   task automatic idle();
      op(1'b0, no_op);
   endtask

   task automatic t_reset();
      chk("pc", pc_out, 11'h000);
      chk("sp", 11'(sp_out), 11'h000);
      chk("bank", 11'(bank_out), 11'h000);
      chk("table", 11'(periph_num[4]), 11'h000);
      $display("test reset done");
   endtask

   task automatic t_alu();
      // operand b comes from the ram word at row and column
      op(1, no_op); op(1, clear_carry_op); op(1, load_imm_op, 4'h8); op(1, ram_store_op);
      op(1, load_imm_op, 4'h9); op(1, add_op); idle();
      chk("add acc", 11'(accum_out), 11'h001);
      chk("add cy", 11'(carry_out), 11'h001);
      chk("add st", 11'(branch_out), 11'h001);
      op(1, load_imm_op, 4'h5); op(1, ram_store_op);
      op(1, load_imm_op, 4'h3); op(1, set_carry_op); op(1, sub_op); idle();
      chk("sub acc", 11'(accum_out), 11'h00E);
      chk("sub cy", 11'(carry_out), 11'h000);
      chk("sub st", 11'(branch_out), 11'h000);
      op(1, load_imm_op, 4'h6); op(1, ram_store_op); op(1, compare_op); idle(); idle(); idle();
      chk("cmp st", 11'(branch_out), 11'h000);
      chk("cmp acc", 11'(accum_out), 11'h006);
      op(1, load_imm_op, 4'h3); op(1, ram_store_op); op(1, load_imm_op, 4'hC); op(1, and_op);
      idle();
      chk("and st", 11'(branch_out), 11'h000);
      op(1, set_carry_op); op(1, load_imm_op, 4'h0); op(1, rotate_left_op); idle();
      chk("rol acc", 11'(accum_out), 11'h001);
      chk("rol cy", 11'(carry_out), 11'h000);
      $display("test alu done");
   endtask

   task automatic t_pc();
      op(1, long_jump_op, 4'h0, 11'h7C5); idle();
      chk("long jump", pc_out, 11'h7C5);
      op(1, page_jump_op, 4'h0, 11'h03A); op(1, load_imm_op, 4'h6); idle();
      chk("page jump", pc_out, 11'h7FB);
      op(1, ram_store_op); op(1, compare_op); op(1, cond_branch_op, 4'h0, 11'h005); idle();
      chk("not taken", pc_out, 11'h7FE);
      op(1, load_imm_op, 4'h1); op(1, cond_branch_op, 4'h0, 11'h005); idle();
      chk("taken", pc_out, 11'h7C5);
      $display("test pc done");
   endtask

   task automatic t_stack();
      op(1, call_op, 4'h0, 11'h100); idle();
      chk("call pc", pc_out, 11'h100);
      chk("call sp", 11'(sp_out), 11'h001);
      op(1, return_op); idle();
      chk("ret pc", pc_out, 11'h7C6);
      chk("ret sp", 11'(sp_out), 11'h000);
      for (int k = 0; k < 8; k++) op(1, call_op, 4'h0, 11'h200);
      idle();
      chk("wrap sp", 11'(sp_out), 11'h000);
      op(1, call_op, 4'h0, 11'h300); op(1, return_op); idle();
      chk("pair pc", pc_out, 11'h201);
      op(1, load_imm_op, 4'h9); op(1, set_carry_op); op(1, interrupt_entry_op, 4'h0, 11'h040);
      op(1, load_imm_op, 4'h2); op(1, clear_carry_op); op(1, interrupt_return_op); idle();
      chk("interrupt_return_op pc", pc_out, 11'h203);
      chk("interrupt_return_op acc", 11'(accum_out), 11'h009);
      chk("interrupt_return_op cy", 11'(carry_out), 11'h001);
      chk("interrupt_return_op sp", 11'(sp_out), 11'h000);
      $display("test stack done");
   endtask

   task automatic t_periph();
      op(1, set_bank_flag_op); op(1, load_imm_op, 4'h0); op(1, move_to_col_op);
      op(1, load_imm_op, 4'h1); op(1, periph_write_op); idle();
      chk("bank", 11'(bank_out), 11'h001);
      chk("tbl num", 11'(periph_num), 11'h010);
      chk("no wr", 11'(periph_wr), 11'h000);
      op(1, load_imm_op, 4'h5); op(1, move_to_col_op); op(1, load_imm_op, 4'hA);
      op(1, periph_write_op); idle();
      chk("wr", 11'(periph_wr), 11'h001);
      chk("wnum", 11'(periph_wnum), 11'h015);
      chk("wdata", 11'(periph_wdata), 11'h00A);
      op(1, periph_read_op);
      chk("wr end", 11'(periph_wr), 11'h000);
      chk("rd", 11'(periph_rd), 11'h001);
      idle();
      chk("rd acc", 11'(accum_out), 11'h006);
      op(1, load_imm_op, 4'h0); op(1, move_to_col_op); op(1, periph_write_op);
      op(1, clear_bank_flag_op); idle();
      chk("tbl0", 11'(periph_num[4]), 11'h000);
      chk("bank0", 11'(bank_out), 11'h000);
      $display("test peripheral done");
   endtask

   task automatic t_ram();
      op(1, load_imm_op, 4'hB); op(1, move_to_row_op); op(1, load_imm_op, 4'h2);
      op(1, move_to_col_op); op(1, load_imm_op, 4'h5); op(1, ram_store_op);
      op(1, load_imm_op, 4'h3); op(1, move_to_row_op); op(1, load_imm_op, 4'h0);
      op(1, ram_load_op); idle();
      chk("ram alias", 11'(accum_out), 11'h005);
      op(1, bit_set_op, 4'h0, 11'h000, 2'h1); op(1, ram_load_op); idle();
      chk("bit set", 11'(accum_out), 11'h007);
      op(1, set_bank_flag_op); op(1, load_imm_op, 4'h4); op(1, move_to_row_op);
      op(1, load_imm_op, 4'h9); idle();
      chk("lookup", lookup_addr, 11'h049);
      op(1, rom_to_ram_transfer_op); op(1, clear_bank_flag_op); op(1, ram_load_op); idle();
      chk("rom to ram", 11'(accum_out), 11'h003);
      $display("test ram done");
   endtask

   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   initial begin
      repeat (20) @(posedge sys_clk);
      rst <= 1'b0;
      #1;
      t_reset();
      t_alu();
      t_pc();
      t_stack();
      t_periph();
      t_ram();
      stop_test();
   end
endmodule // ncd_core_tb
